// [rtl/tlb_pkg.sv]
// tlb_pkg: constants, field layout and carrier types for the translation unit
// assumes the unit itself decodes privilege and the control area, not the core
package tlb_pkg;

  // register addresses inside the on-chip control area
  localparam logic [31:0] TRANSLATION_CONTROL_ADDR = 32'h0FFFFFE0;
  localparam logic [31:0] TABLE_BASE_ADDR = 32'h0FFFFFF8;
  localparam logic [31:0] FAULT_ADDRESS_ADDR = 32'h0FFFFFFC;
  localparam logic [31:0] ENTRY_HIGH_ADDR = 32'hFFFFFFF0;
  localparam logic [31:0] ENTRY_LOW_ADDR = 32'hFFFFFFF4;

  // translation_control_reg fields
  localparam int MMU_ENABLE_BIT = 0;
  localparam int INDEX_HASH_BIT = 1;
  localparam int FLUSH_BIT = 2;
  localparam int REPLACE_WAY_LSB = 4;
  localparam int SINGLE_SPACE_BIT = 8;
  localparam logic [31:0] CONTROL_RESET = 32'h00000000;

  // entry_high_reg fields
  localparam int VPN_LSB = 10;
  localparam int TAG_LSB = 0;

  // entry_low_reg fields
  localparam int PPN_LSB = 10;
  localparam int VALID_BIT = 8;
  localparam int RIGHTS_LSB = 5;
  localparam int SIZE_BIT = 4;
  localparam int BUFFERED_BIT = 3;
  localparam int WRITTEN_BIT = 2;
  localparam int GLOBAL_BIT = 1;

  // exception codes reported with a fault
  localparam logic [11:0] MISS_LOAD_CODE = 12'h040;
  localparam logic [11:0] MISS_STORE_CODE = 12'h060;
  localparam logic [11:0] PROTECT_LOAD_CODE = 12'h0A0;
  localparam logic [11:0] PROTECT_STORE_CODE = 12'h0C0;

  typedef enum logic [1:0] {FAULT_NONE, FAULT_MISS, FAULT_PROTECT, FAULT_FIRST_WRITE} fault_t;

  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic [7:0] process_tag;
    logic [18:0] ppn;
    logic [1:0] access_rights_field;
    logic page_size_flag;
    logic buffered;
    logic written;
    logic global_page_flag;
  } entry_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic privileged_flag;
    logic [31:0] addr;
  } access_req_t;

  typedef struct packed {
    logic valid;
    logic translated;
    logic [31:0] phys_addr;
    logic cacheable;
    fault_t fault;
    logic [11:0] code;
  } access_res_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic privileged_flag;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// [rtl/tlb_translation_unit.sv]
// tlb_translation_unit: 4-way translation buffer, page checks and the five mmu registers
// assumes one access request per cycle from the core; results return one cycle later
`timescale 1ns/1ns

module tlb_translation_unit #(
  parameter int WAYS = 4,
  parameter int SETS = 32,
  parameter logic [11:0] FIRST_WRITE_LOAD_CODE = 12'h000,
  parameter logic [11:0] FIRST_WRITE_STORE_CODE = 12'h000
) (
  input wire logic clock_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire tlb_pkg::access_req_t access_i, // core fetch or data access
  output tlb_pkg::access_res_t result_o, // translation result, one cycle later
  input wire tlb_pkg::reg_req_t reg_i, // control area register access
  output logic reg_ack_o, // register access answered
  output logic [31:0] reg_rdata_o, // register read data
  input wire logic load_entry_i, // load entry instruction pulse
  input wire logic address_error_i, // core address error pulse
  input wire logic [31:0] address_error_addr_i // address that caused it
);

  tlb_pkg::entry_t entries [WAYS][SETS];
  logic [SETS-1:0] valid_bits [WAYS];

  // control and entry_high fields live in separate flops; the other three registers are whole words
  logic mmu_enable_bit;
  logic index_hash_select;
  logic single_space_flag;
  logic [1:0] replace_way;
  logic [21:0] entry_vpn;
  logic [7:0] process_tag;
  logic [31:0] entry_low_reg;
  logic [31:0] table_base_reg;
  logic [31:0] fault_address_reg;

  // lookup and classification, all combinational from the standing access
  logic [4:0] index;
  logic [WAYS-1:0] way_hit;
  logic any_hit;
  tlb_pkg::entry_t hit_entry;
  logic needs_translation;
  tlb_pkg::fault_t next_fault;
  logic [11:0] next_code;
  logic [31:0] next_phys;
  logic fault_now;
  logic [4:0] load_index;
  logic reg_write;

  // set index from page bits, optionally hashed with the process tag
  function automatic logic [4:0] set_index(input logic [4:0] page_bits, input logic [7:0] tag, input logic hash);
    if (hash) begin
      set_index = page_bits ^ tag[4:0];
    end else begin
      set_index = page_bits;
    end
  endfunction

  // rights table: privileged and user reads and writes
  function automatic logic rights_allow(input logic [1:0] rights, input logic priv, input logic write);
    logic ok;
    ok = 1'b0;
    unique case (rights)
      2'b00: ok = priv && !write;
      2'b01: ok = priv;
      2'b10: ok = !write;
      2'b11: ok = 1'b1;
    endcase
    rights_allow = ok;
  endfunction

  // register decode needs the exact address and privilege
  function automatic logic reg_hit(input tlb_pkg::reg_req_t req, input logic [31:0] where);
    reg_hit = req.valid && req.privileged_flag && req.addr == where;
  endfunction

  // page number compare; 4k entries ignore bits 11 and 10
  function automatic logic page_equal(input tlb_pkg::entry_t e, input logic [31:0] addr);
    page_equal = e.virtual_page_number[21:2] == addr[31:12] && (e.page_size_flag || e.virtual_page_number[1:0] == addr[11:10]);
  endfunction

  // tag compare, skipped for global pages and privileged single space
  function automatic logic tag_equal(input tlb_pkg::entry_t e, input logic [7:0] tag, input logic skip);
    tag_equal = e.global_page_flag || skip || e.process_tag == tag;
  endfunction

  // 4k pages keep twelve offset bits, 1k pages ten
  function automatic logic [31:0] page_phys(input tlb_pkg::entry_t e, input logic [31:0] addr);
    if (e.page_size_flag) begin
      page_phys = {3'b000, e.ppn[18:2], addr[11:0]};
    end else begin
      page_phys = {3'b000, e.ppn, addr[9:0]};
    end
  endfunction

  // only P0, U0 and P3 go through the buffer; P1, P2, P4 map fixed
  assign needs_translation = mmu_enable_bit && (!access_i.addr[31] || access_i.addr[31:29] == 3'b110);
  // the set index follows the tag, so changing the hash needs a flush
  assign index = set_index(access_i.addr[16:12], process_tag, index_hash_select);
  assign load_index = set_index(entry_vpn[6:2], process_tag, index_hash_select);
  assign reg_write = reg_i.write;

  // parallel compare of the indexed entry in every way
  always_comb begin
    tlb_pkg::entry_t e;
    logic page_match;
    logic tag_match;
    e = '0;
    page_match = 1'b0;
    tag_match = 1'b0;
    way_hit = '0;
    for (int w = 0; w < WAYS; w++) begin
      e = entries[w][index];
      page_match = page_equal(e, access_i.addr);
      tag_match = tag_equal(e, process_tag, single_space_flag && access_i.privileged_flag);
      way_hit[w] = valid_bits[w][index] && page_match && tag_match;
    end
  end

  // lowest hitting way wins; several hits are the caller's problem
  always_comb begin
    hit_entry = '0;
    any_hit = |way_hit;
    // count down so way 0 is written last and wins
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (way_hit[w]) begin
        hit_entry = entries[w][index];
      end
    end
  end

  // classify the access; protection is checked before first write
  always_comb begin
    next_fault = tlb_pkg::FAULT_NONE;
    next_code = 12'h000;
    // fixed areas and disabled mode: top three bits cleared, nothing checked
    next_phys = {3'b000, access_i.addr[28:0]};
    if (needs_translation) begin
      next_phys = page_phys(hit_entry, access_i.addr);
      // miss first: an absent entry has no rights or written flag to check
      if (!any_hit) begin
        next_fault = tlb_pkg::FAULT_MISS;
        next_code = access_i.write ? tlb_pkg::MISS_STORE_CODE : tlb_pkg::MISS_LOAD_CODE;
      end else if (!rights_allow(hit_entry.access_rights_field, access_i.privileged_flag, access_i.write)) begin
        next_fault = tlb_pkg::FAULT_PROTECT;
        next_code = access_i.write ? tlb_pkg::PROTECT_STORE_CODE : tlb_pkg::PROTECT_LOAD_CODE;
      end else if (access_i.write && !hit_entry.written) begin
        next_fault = tlb_pkg::FAULT_FIRST_WRITE;
        next_code = FIRST_WRITE_STORE_CODE;
      end
    end
  end

  // any fault of a standing request drives the capture registers
  assign fault_now = access_i.valid && next_fault != tlb_pkg::FAULT_NONE;

  // registered result toward the core and cache
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= '0;
    end else begin
      result_o.valid <= access_i.valid;
      // marks accesses that went through the buffer
      result_o.translated <= access_i.valid && needs_translation;
      result_o.phys_addr <= next_phys;
      // fixed areas report cacheable; the cache control decides P2 itself
      result_o.cacheable <= needs_translation ? hit_entry.buffered : 1'b1;
      // quiet fault and code when idle, so a stale address cannot report
      result_o.fault <= access_i.valid ? next_fault : tlb_pkg::FAULT_NONE;
      result_o.code <= access_i.valid ? next_code : 12'h000;
    end
  end

  // entry storage has no reset; only the valid bits need one
  always_ff @(posedge clock_i) begin
    if (load_entry_i) begin
      // index comes from entry_high, not from the access in flight
      entries[replace_way][load_index] <= '{
        virtual_page_number: entry_vpn,
        process_tag: process_tag,
        ppn: entry_low_reg[28:tlb_pkg::PPN_LSB],
        access_rights_field: entry_low_reg[tlb_pkg::RIGHTS_LSB +: 2],
        page_size_flag: entry_low_reg[tlb_pkg::SIZE_BIT],
        buffered: entry_low_reg[tlb_pkg::BUFFERED_BIT],
        written: entry_low_reg[tlb_pkg::WRITTEN_BIT],
        global_page_flag: entry_low_reg[tlb_pkg::GLOBAL_BIT]
      };
    end
  end

  // valid bits: flush clears all, a load in the same cycle still lands
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int w = 0; w < WAYS; w++) begin
        valid_bits[w] <= '0;
      end
    end else begin
      for (int w = 0; w < WAYS; w++) begin
        // a flush drops every way at once
        if (reg_hit(reg_i, tlb_pkg::TRANSLATION_CONTROL_ADDR) && reg_write && reg_i.wdata[tlb_pkg::FLUSH_BIT]) begin
          valid_bits[w] <= '0;
        end
        // placed after the flush, so the loaded entry keeps its own bit
        if (load_entry_i && replace_way == w[1:0]) begin
          valid_bits[w][load_index] <= entry_low_reg[tlb_pkg::VALID_BIT];
        end
      end
    end
  end

  // translation control; a miss moves the replacement way, over any software write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // single space starts cleared too, for a defined start
      mmu_enable_bit <= tlb_pkg::CONTROL_RESET[tlb_pkg::MMU_ENABLE_BIT];
      index_hash_select <= tlb_pkg::CONTROL_RESET[tlb_pkg::INDEX_HASH_BIT];
      single_space_flag <= tlb_pkg::CONTROL_RESET[tlb_pkg::SINGLE_SPACE_BIT];
      replace_way <= tlb_pkg::CONTROL_RESET[tlb_pkg::REPLACE_WAY_LSB +: 2];
    end else begin
      // flush is not stored; it acts on the valid bits only
      if (reg_hit(reg_i, tlb_pkg::TRANSLATION_CONTROL_ADDR) && reg_write) begin
        mmu_enable_bit <= reg_i.wdata[tlb_pkg::MMU_ENABLE_BIT];
        index_hash_select <= reg_i.wdata[tlb_pkg::INDEX_HASH_BIT];
        single_space_flag <= reg_i.wdata[tlb_pkg::SINGLE_SPACE_BIT];
        replace_way <= reg_i.wdata[tlb_pkg::REPLACE_WAY_LSB +: 2];
      end
      // lowest invalid way first, then a rotating way once the set is full
      if (fault_now && next_fault == tlb_pkg::FAULT_MISS) begin
        if (!valid_bits[0][index]) begin
          replace_way <= 2'd0;
        end else if (!valid_bits[1][index]) begin
          replace_way <= 2'd1;
        end else if (!valid_bits[2][index]) begin
          replace_way <= 2'd2;
        end else if (!valid_bits[3][index]) begin
          replace_way <= 2'd3;
        end else begin
          // the 2-bit wrap is intended
          replace_way <= replace_way + 2'd1;
        end
      end
    end
  end

  // entry_high: hardware capture of the page number beats software
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_vpn <= '0;
      process_tag <= '0;
    end else begin
      if (reg_hit(reg_i, tlb_pkg::ENTRY_HIGH_ADDR) && reg_write) begin
        // software rewrites both halves, but a capture in the same cycle keeps its page number
        entry_vpn <= reg_i.wdata[31:tlb_pkg::VPN_LSB];
        process_tag <= reg_i.wdata[tlb_pkg::TAG_LSB +: 8];
      end
      // the tag is software only; hardware rewrites just the page number
      if (fault_now) begin
        entry_vpn <= access_i.addr[31:10];
      end else if (address_error_i) begin
        entry_vpn <= address_error_addr_i[31:10];
      end
    end
  end

  // fault address: held until the next fault, address error or software write replaces it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_address_reg <= '0;
    end else begin
      // an access fault outranks a core address error in the same cycle
      if (fault_now) begin
        fault_address_reg <= access_i.addr;
      end else if (address_error_i) begin
        fault_address_reg <= address_error_addr_i;
      end else if (reg_hit(reg_i, tlb_pkg::FAULT_ADDRESS_ADDR) && reg_write) begin
        fault_address_reg <= reg_i.wdata;
      end
    end
  end

  // entry_low and table base: software only, no hardware path
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_low_reg <= '0;
      table_base_reg <= '0;
    end else begin
      // nothing in hardware writes these two, so a fault never disturbs them
      if (reg_hit(reg_i, tlb_pkg::ENTRY_LOW_ADDR) && reg_write) begin
        entry_low_reg <= reg_i.wdata;
      end
      if (reg_hit(reg_i, tlb_pkg::TABLE_BASE_ADDR) && reg_write) begin
        table_base_reg <= reg_i.wdata;
      end
    end
  end

  // read path; user-mode or unknown addresses read as zero
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_ack_o <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      // every request is answered, mapped or not, so the core never stalls
      reg_ack_o <= reg_i.valid;
      reg_rdata_o <= '0;
      if (reg_i.valid && !reg_i.write && reg_i.privileged_flag) begin
        // flush reads back as zero, as do bits 9:8 of entry_high
        unique case (reg_i.addr)
          tlb_pkg::TRANSLATION_CONTROL_ADDR: reg_rdata_o <= {23'h0, single_space_flag, 2'b00, replace_way,
                                                             2'b00, index_hash_select, mmu_enable_bit};
          tlb_pkg::ENTRY_HIGH_ADDR: reg_rdata_o <= {entry_vpn, 2'b00, process_tag};
          tlb_pkg::ENTRY_LOW_ADDR: reg_rdata_o <= entry_low_reg;
          tlb_pkg::TABLE_BASE_ADDR: reg_rdata_o <= table_base_reg;
          tlb_pkg::FAULT_ADDRESS_ADDR: reg_rdata_o <= fault_address_reg;
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end

endmodule

// [tb/core_model.sv]
// core_model: processor core issuing register, fetch and data requests
// assumes the unit answers one cycle after taking a request
`timescale 1ns/1ns
module core_model (
  input wire logic clock_i, // core clock
  output tlb_pkg::access_req_t access_o, // access to translate
  input wire tlb_pkg::access_res_t result_i, // translation result
  output tlb_pkg::reg_req_t reg_o, // register access
  input wire logic reg_ack_i, // register answer
  input wire logic [31:0] reg_rdata_i, // register read data
  output logic load_entry_o, // load entry pulse
  output logic address_error_o, // address error pulse
  output logic [31:0] address_error_addr_o // faulting address
);
  int hangs;
  // idle from time zero
  initial begin
    access_o = '0;
    reg_o = '0;
    load_entry_o = 1'b0;
    address_error_o = 1'b0;
    address_error_addr_o = 32'h0;
    hangs = 0;
  end
  // one-cycle request; data lines scrambled after so stale values never match
  task automatic reg_acc(input logic w, p, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    @(posedge clock_i);
    reg_o <= '{1'b1, w, p, a, d};
    @(posedge clock_i);
    reg_o <= '{1'b0, w, p, ~a, ~d};
    for (n = 0; n < 8 && reg_ack_i !== 1'b1; n++) @(posedge clock_i);
    if (n == 8) hangs++;
    q = reg_rdata_i;
  endtask
  task automatic access(input logic w, p, input logic [31:0] a, output tlb_pkg::access_res_t r);
    int n;
    @(posedge clock_i);
    access_o <= '{1'b1, w, p, a};
    @(posedge clock_i);
    access_o <= '{1'b0, w, p, ~a};
    for (n = 0; n < 8 && result_i.valid !== 1'b1; n++) @(posedge clock_i);
    if (n == 8) hangs++;
    r = result_i;
  endtask
  // load entry or address error, one cycle wide
  task automatic pulse(input logic err, input logic [31:0] a);
    @(posedge clock_i);
    load_entry_o <= !err;
    address_error_o <= err;
    address_error_addr_o <= a;
    @(posedge clock_i);
    load_entry_o <= 1'b0;
    address_error_o <= 1'b0;
    address_error_addr_o <= ~a;
  endtask
endmodule

// [tb/tlb_translation_unit_assertions.sv]
// tlb_checker: port-level timing and result properties of the translation unit
// assumes one clock domain; bound into the unit below
`timescale 1ns/1ns
module tlb_checker (
  input wire logic clock_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire tlb_pkg::access_req_t access_i, // core access
  input wire tlb_pkg::access_res_t result_o, // access result
  input wire tlb_pkg::reg_req_t reg_i, // register access
  input wire logic reg_ack_o, // register answer
  input wire logic [31:0] reg_rdata_o // register read data
);
  logic mapped;
  logic [28:0] prev_low;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // the five register addresses; anything else must read zero
  assign mapped = reg_i.addr inside {tlb_pkg::TRANSLATION_CONTROL_ADDR, tlb_pkg::TABLE_BASE_ADDR,
    tlb_pkg::FAULT_ADDRESS_ADDR, tlb_pkg::ENTRY_HIGH_ADDR, tlb_pkg::ENTRY_LOW_ADDR};
  // low bits of the last request, kept for the fixed kernel mapping
  always_ff @(posedge clock_i) prev_low <= access_i.addr[28:0];
  sequence s_miss;
    access_i.valid ##1 (result_o.valid && result_o.fault == tlb_pkg::FAULT_MISS);
  endsequence
  reg_answer_a: assert property (reg_i.valid |=> reg_ack_o)
    else $error("register access not answered");
  ack_cause_a: assert property (reg_ack_o |-> $past(reg_i.valid))
    else $error("answer without register access");
  user_zero_a: assert property (reg_i.valid && !reg_i.privileged_flag |=> reg_rdata_o == 32'h0)
    else $error("user access returned data");
  unmapped_zero_a: assert property (reg_i.valid && !mapped |=> reg_rdata_o == 32'h0)
    else $error("unmapped address returned data");
  result_timing_a: assert property (access_i.valid |=> result_o.valid)
    else $error("access result missing");
  kernel_bypass_a: assert property (access_i.valid && access_i.addr[31:30] == 2'b10 |=>
    !result_o.translated && result_o.fault == tlb_pkg::FAULT_NONE && result_o.phys_addr == {3'h0, prev_low})
    else $error("fixed kernel area not bypassed");
  miss_code_a: assert property (s_miss |-> result_o.code ==
    ($past(access_i.write) ? tlb_pkg::MISS_STORE_CODE : tlb_pkg::MISS_LOAD_CODE))
    else $error("wrong miss code");
  read_first_write_a: assert property (access_i.valid && !access_i.write |=>
    result_o.fault != tlb_pkg::FAULT_FIRST_WRITE)
    else $error("first write fault on a read");
endmodule
bind tlb_translation_unit tlb_checker tlb_checker_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .access_i(access_i),
  .result_o(result_o), .reg_i(reg_i), .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o));

// [tb/tlb_translation_unit_bench.sv]
// tlb_translation_unit_bench: registers, faults, rights and lookup of the translation unit
// assumes the core model drives every unit input except clock and reset, and the checker is bound in
`timescale 1ns/1ns
module tlb_translation_unit_bench;
  localparam logic [31:0] CT = tlb_pkg::TRANSLATION_CONTROL_ADDR;
  localparam logic [31:0] TB = tlb_pkg::TABLE_BASE_ADDR;
  localparam logic [31:0] FA = tlb_pkg::FAULT_ADDRESS_ADDR;
  localparam logic [31:0] EH = tlb_pkg::ENTRY_HIGH_ADDR;
  localparam logic [31:0] EL = tlb_pkg::ENTRY_LOW_ADDR;
  localparam logic [11:0] FW_CODE = 12'h0E0; // arbitrary first write code
  localparam tlb_pkg::fault_t NO = tlb_pkg::FAULT_NONE, MS = tlb_pkg::FAULT_MISS;
  localparam tlb_pkg::fault_t PV = tlb_pkg::FAULT_PROTECT, FW = tlb_pkg::FAULT_FIRST_WRITE;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_ack_o, load_entry_i, address_error_i, ok;
  logic [31:0] reg_rdata_o, address_error_addr_i, q, ctl;
  logic [31:0] regs [5] = '{CT, TB, FA, EH, EL};
  tlb_pkg::access_req_t access_i;
  tlb_pkg::access_res_t result_o, r;
  tlb_pkg::reg_req_t reg_i;
  int mismatches = 0;
  int n_compared = 0;
  // 250 MHz core clock
  always #2 clock_i = ~clock_i;
  tlb_translation_unit #(.FIRST_WRITE_STORE_CODE(FW_CODE)) tlb_translation_unit_inst (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .access_i(access_i), .result_o(result_o), .reg_i(reg_i), .reg_ack_o(reg_ack_o),
    .reg_rdata_o(reg_rdata_o), .load_entry_i(load_entry_i), .address_error_i(address_error_i),
    .address_error_addr_i(address_error_addr_i));
  core_model core_model_inst (.clock_i(clock_i), .access_o(access_i), .result_i(result_o), .reg_o(reg_i),
    .reg_ack_i(reg_ack_o), .reg_rdata_i(reg_rdata_o), .load_entry_o(load_entry_i),
    .address_error_o(address_error_i), .address_error_addr_o(address_error_addr_i));
  task automatic chk_w(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // x is the physical address when no fault is expected, else the code
  task automatic chk_a(input tlb_pkg::fault_t f, input logic [31:0] x);
    chk_w(f == NO ? r.phys_addr : {20'h0, r.code}, x);
    chk_w({30'h0, r.fault}, {30'h0, f});
  endtask
  task automatic rc(input logic [31:0] a, e);
    core_model_inst.reg_acc(1'b0, 1'b1, a, 32'h0, q);
    chk_w(q, e);
  endtask
  task automatic wr(input logic [31:0] a, d);
    core_model_inst.reg_acc(1'b1, 1'b1, a, d, q);
  endtask
  task automatic ac(input logic w, p, input logic [31:0] a);
    core_model_inst.access(w, p, a, r);
  endtask
  // entry low word with a fixed page number of 0x120
  function automatic logic [31:0] low(input logic [1:0] pr, input logic sz, c, d, g);
    return {3'h0, 19'h120, 2'h1, 1'h0, pr, sz, c, d, g, 1'h0};
  endfunction
  // one live entry per set, so no access hits twice
  task automatic ld(input logic [31:0] eh, el);
    wr(EH, eh);
    wr(EL, el);
    wr(CT, ctl); // written as if from the untranslated kernel area
    core_model_inst.pulse(1'b0, 32'h0);
  endtask
  task automatic tally_and_finish();
    mismatches += core_model_inst.hangs;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a bounded wait that ran out ends the run
  always @(posedge clock_i) if (core_model_inst.hangs != 0) tally_and_finish();
  initial begin
    ctl = 32'h1;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (regs[i]) rc(regs[i], 32'h0);
    wr(TB, 32'hA5A5A5A4);
    core_model_inst.reg_acc(1'b0, 1'b0, TB, 32'h0, q);
    chk_w(q, 32'h0);
    core_model_inst.reg_acc(1'b1, 1'b0, EL, 32'hFFFFFFFF, q);
    rc(EL, 32'h0);
    rc(TB, 32'hA5A5A5A4);
    rc(32'h0FFFFFE4, 32'h0);
    ac(1'b1, 1'b0, 32'h00001000);
    chk_a(NO, 32'h00001000);
    $display("registers and disabled test finished");
    wr(CT, ctl);
    ac(1'b0, 1'b0, 32'h00012C00);
    chk_a(MS, 32'h040);
    rc(EH, 32'h00012C00);
    ac(1'b1, 1'b0, 32'h00013000);
    chk_a(MS, 32'h060);
    ac(1'b0, 1'b1, 32'hA0001234);
    chk_a(NO, 32'h00001234);
    chk_w({31'h0, r.translated}, 32'h0);
    rc(FA, 32'h00013000);
    rc(EL, 32'h0);
    core_model_inst.pulse(1'b1, 32'hDEADBEEC);
    rc(FA, 32'hDEADBEEC);
    rc(EH, 32'hDEADBC00);
    $display("fault capture test finished");
    for (int p = 0; p < 4; p++) begin
      ld(32'h00040000, low(p[1:0], 1'b0, 1'b1, 1'b1, 1'b0));
      for (int k = 0; k < 4; k++) begin
        ac(k[0], k[1], 32'h00040010);
        ok = k[1] ? (!k[0] || p[0]) : (p == 3 || (!k[0] && p[1]));
        chk_a(ok ? NO : PV, ok ? 32'h00048010 : (k[0] ? 32'h0C0 : 32'h0A0));
      end
    end
    chk_w({31'h0, r.cacheable}, 32'h1);
    ld(32'h00040000, low(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
    ac(1'b1, 1'b1, 32'h00040010);
    chk_a(FW, {20'h0, FW_CODE});
    ac(1'b0, 1'b1, 32'h00040010);
    chk_a(NO, 32'h00048010);
    chk_w({31'h0, r.cacheable}, 32'h0);
    ld(32'h00040000, low(2'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    ac(1'b1, 1'b0, 32'h00040010);
    chk_a(PV, 32'h0C0);
    $display("rights test finished");
    ac(1'b0, 1'b1, 32'h00040C10);
    chk_a(MS, 32'h040);
    ld(32'h00040000, low(2'h3, 1'b1, 1'b1, 1'b1, 1'b0));
    ac(1'b0, 1'b1, 32'h00040C10);
    chk_a(NO, 32'h00048C10);
    chk_w({31'h0, r.translated}, 32'h1);
    for (int g = 0; g < 2; g++) begin
      ld(32'h00040005, low(2'h3, 1'b0, 1'b1, 1'b1, g[0]));
      wr(EH, 32'h00040006);
      ac(1'b0, 1'b0, 32'h00040010);
      chk_a(g ? NO : MS, g ? 32'h00048010 : 32'h040);
    end
    ctl = 32'h125; // single space changes, so flush goes with it; entry lands in way 2
    ld(32'h00040005, low(2'h3, 1'b0, 1'b1, 1'b1, 1'b0));
    rc(CT, 32'h00000121);
    wr(EH, 32'h00040006);
    ac(1'b0, 1'b1, 32'h00040010);
    chk_a(NO, 32'h00048010);
    ac(1'b0, 1'b0, 32'h00040010);
    chk_a(MS, 32'h040);
    rc(CT, 32'h00000101);
    $display("compare test finished");
    ctl = 32'h7; // hash select changes, so flush goes with it
    ld(32'h00003003, low(2'h3, 1'b0, 1'b1, 1'b1, 1'b1));
    ac(1'b0, 1'b1, 32'h00003010);
    chk_a(NO, 32'h00048010);
    wr(EH, 32'h00003000);
    ac(1'b0, 1'b1, 32'h00003010);
    chk_a(MS, 32'h040);
    wr(EH, 32'h00003003);
    wr(CT, ctl);
    ac(1'b0, 1'b1, 32'h00003010);
    chk_a(MS, 32'h040);
    wr(EH, 32'h00040FFF);
    rc(EH, 32'h00040CFF);
    $display("hash and flush test finished");
    tally_and_finish();
  end
endmodule
